/* File: common/panel_pkg.sv */
package panel_pkg;

  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SLOW_OSC_HZ = 32_768;
  localparam int FAST_OSC_HZ = 1_000_000;
  // divide ratios round down, so the emulated slow oscillator runs slightly fast; the fast one divides exactly
  localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_OSC_HZ;
  localparam int FAST_DIV = SYS_CLK_HZ / FAST_OSC_HZ;
  localparam int DIV_W = 10;
  localparam int DEBOUNCE_US = 10_000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (SYS_CLK_HZ / 1_000_000);
  localparam int CONFIG_CYCLES = 1_000;

  // ***************************************************************
  // program address layout and reset vector
  // ***************************************************************
  localparam int BANK_W = 1;
  localparam int PAGE_W = 4;
  localparam int STEP_W = 8;
  localparam int PC_W = BANK_W + PAGE_W + STEP_W;
  localparam logic [BANK_W-1:0] RESET_BANK = 1'h0;
  localparam logic [PAGE_W-1:0] RESET_PAGE = 4'h1;
  localparam logic [STEP_W-1:0] RESET_STEP = 8'h00;

  // ***************************************************************
  // core control registers mirrored on the panel
  // ***************************************************************
  localparam logic [7:0] OSC_CTRL_ADDR = 8'hE9;
  localparam logic [7:0] POWER_CTRL_ADDR = 8'hFA;
  localparam int FAST_OSC_CTRL_POS = 1;
  localparam int HEAVY_LOAD_POS = 3;
  localparam int SUPPLY_DETECT_POS = 1;

  // ***************************************************************
  // bus registers
  // ***************************************************************
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_PC = 32'h0000_0008;
  localparam int CTRL_CLK_SEL_POS = 0;
  localparam int CTRL_EXTRA_SUPPLY_POS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_HALT_POS = 0;
  localparam int STAT_DONE_POS = 1;
  localparam int STAT_CLK_SEL_POS = 2;

  // ***************************************************************
  // keys
  // ***************************************************************
  localparam int NUM_KEYS = 3;
  localparam int KEY_RUN = 0;
  localparam int KEY_STEP = 1;
  localparam int KEY_RESET = 2;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_STEP = 2'b11
  } dbg_state_t;

endpackage

/* File: common/key_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface key_if;
  logic [panel_pkg::NUM_KEYS-1:0] press;
  modport cond (output press);
  modport panel (input press);
endinterface
`default_nettype wire

/* File: src/key_conditioner.sv */
`timescale 1ns/1ns
`default_nettype none
module key_conditioner #(
  parameter int DEBOUNCE = panel_pkg::DEBOUNCE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [panel_pkg::NUM_KEYS-1:0] keys_raw,
  key_if.cond kif
);
  import panel_pkg::*;

  localparam int CNT_W = $clog2(DEBOUNCE + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE - 1);

  logic sync1_q [NUM_KEYS];
  logic sync2_q [NUM_KEYS];
  logic stable_q [NUM_KEYS];
  logic press_q [NUM_KEYS];
  logic [CNT_W-1:0] cnt_q [NUM_KEYS];

  genvar i;
  generate
    for (i = 0; i < NUM_KEYS; i++) begin : g_key
      // two-stage synchroniser; only sync2 is looked at
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= keys_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end

      // level must hold a full debounce time before it is believed
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cnt_q[i] <= '0;
          stable_q[i] <= 1'b0;
          press_q[i] <= 1'b0;
        end else begin
          press_q[i] <= 1'b0;
          if (sync2_q[i] == stable_q[i]) begin
            cnt_q[i] <= '0;
          end else if (cnt_q[i] == CNT_LAST) begin
            cnt_q[i] <= '0;
            stable_q[i] <= sync2_q[i];
            press_q[i] <= sync2_q[i];
          end else begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
          end
        end
      end

      assign kif.press[i] = press_q[i];
    end
  endgenerate

endmodule
`default_nettype wire

/* File: src/debug_panel.sv */
`timescale 1ns/1ns
`default_nettype none
module debug_panel #(
  parameter int DEBOUNCE = panel_pkg::DEBOUNCE_CYCLES,
  parameter int RAM_AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic break_enable_switch,
  input wire logic [panel_pkg::BANK_W-1:0] break_bank_switches,
  input wire logic [panel_pkg::PAGE_W-1:0] break_page_switches,
  input wire logic [panel_pkg::STEP_W-1:0] break_step_switches,
  input wire logic [RAM_AW-1:0] ram_select_switches,
  input wire logic run_key,
  input wire logic step_key,
  input wire logic reset_switch,
  input wire logic [panel_pkg::BANK_W-1:0] pc_bank,
  input wire logic [panel_pkg::PAGE_W-1:0] pc_page,
  input wire logic [panel_pkg::STEP_W-1:0] pc_step,
  input wire logic [7:0] prog_low_data,
  input wire logic [3:0] prog_high_data,
  input wire logic [3:0] ram_read_data,
  input wire logic [7:0] stack_ptr,
  input wire logic [11:0] index_x,
  input wire logic [11:0] index_y,
  input wire logic [3:0] acc_a,
  input wire logic [3:0] acc_b,
  input wire logic int_flag,
  input wire logic dec_flag,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic [3:0] power_ctrl_reg,
  input wire logic [3:0] osc_ctrl_reg,
  input wire logic port3_bit3_out,
  input wire logic port3_bit3_drive,
  input wire logic port3_bit3_pin_i,
  output logic port3_bit3_pin_o,
  output logic port3_bit3_pin_oe_n,
  output logic port3_bit3_to_core,
  output logic cpu_exec_en,
  output logic cpu_reset,
  output logic [panel_pkg::PC_W-1:0] reset_vector,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [3:0] ram_leds,
  output logic [11:0] instruction_word_leds,
  output logic [panel_pkg::BANK_W-1:0] pc_bank_leds,
  output logic [panel_pkg::PAGE_W-1:0] pc_page_leds,
  output logic [panel_pkg::STEP_W-1:0] pc_step_leds,
  output logic [7:0] stack_ptr_leds,
  output logic [11:0] index_x_leds,
  output logic [11:0] index_y_leds,
  output logic [3:0] acc_a_leds,
  output logic [3:0] acc_b_leds,
  output logic interrupt_flag_led,
  output logic decimal_flag_led,
  output logic zero_flag_led,
  output logic carry_flag_led,
  output logic heavy_load_led,
  output logic supply_detect_led,
  output logic fast_osc_led,
  output logic extra_supply_led,
  output logic config_done_led
);
  import panel_pkg::*;

  // ***************************************************************
  // helper functions
  // ***************************************************************
  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] reg_addr);
    addr_is = (a == reg_addr);
  endfunction

  function automatic logic pc_match(input logic [PC_W-1:0] pc, input logic [PC_W-1:0] sw);
    pc_match = (pc == sw);
  endfunction

  // ***************************************************************
  // key conditioning
  // ***************************************************************
  key_if kif ();

  key_conditioner #(.DEBOUNCE(DEBOUNCE)) u_keys (
    .sys_clk(sys_clk),
    .rst(rst),
    .keys_raw({reset_switch, step_key, run_key}),
    .kif(kif)
  );

  wire logic run_p = kif.press[KEY_RUN];
  wire logic step_p = kif.press[KEY_STEP];
  wire logic reset_p = kif.press[KEY_RESET];

  // ***************************************************************
  // power-on configuration
  // ***************************************************************
  localparam int CFG_W = $clog2(CONFIG_CYCLES + 1);
  localparam logic [CFG_W-1:0] CFG_LAST = CFG_W'(CONFIG_CYCLES - 1);
  logic [CFG_W-1:0] cfg_cnt_q;
  logic done_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      cfg_cnt_q <= cfg_cnt_q + 1'b1;
      done_q <= (cfg_cnt_q == CFG_LAST);
    end
  end

  // ***************************************************************
  // bus slave
  // ***************************************************************
  logic [1:0] ctrl_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic addr_phase;
  logic [1:0] ctrl_now;
  dbg_state_t state_q;

  assign addr_phase = hsel && htrans[1] && hready;
  // a ctrl read right behind a write to ctrl must see the new value; status still shows the old clock select
  assign ctrl_now = (wr_pend_q && addr_is(wr_addr_q, ADDR_CTRL)) ? hwdata[1:0] : ctrl_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_pend_q && addr_is(wr_addr_q, ADDR_CTRL)) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (addr_phase && !hwrite) begin
      rdata_q <= '0;
      if (addr_is(haddr, ADDR_CTRL)) begin
        rdata_q[1:0] <= ctrl_now;
      end else if (addr_is(haddr, ADDR_STATUS)) begin
        rdata_q[STAT_HALT_POS] <= (state_q != ST_RUN);
        rdata_q[STAT_DONE_POS] <= done_q;
        rdata_q[STAT_CLK_SEL_POS] <= ctrl_q[CTRL_CLK_SEL_POS];
      end else if (addr_is(haddr, ADDR_PC)) begin
        rdata_q[PC_W-1:0] <= {pc_bank, pc_page, pc_step};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_q;

  // ***************************************************************
  // oscillator emulation
  // ***************************************************************
  localparam logic [DIV_W-1:0] SLOW_LAST = DIV_W'(SLOW_DIV - 1);
  localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_DIV - 1);
  logic [DIV_W-1:0] div_q;
  logic tick_q;
  wire logic [DIV_W-1:0] div_last = ctrl_q[CTRL_CLK_SEL_POS] ? FAST_LAST : SLOW_LAST;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q >= div_last) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ***************************************************************
  // break and step control
  // ***************************************************************
  logic skip_q;

  wire logic brk_hit = break_enable_switch && !skip_q &&
                       pc_match({pc_bank, pc_page, pc_step},
                                {break_bank_switches, break_page_switches, break_step_switches});
  wire logic exec_ok = tick_q && done_q && !cpu_reset &&
                       (((state_q == ST_RUN) && !brk_hit && !step_p) || (state_q == ST_STEP));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
    end else if (!done_q || reset_p) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (step_p) begin
            state_q <= ST_HALT;
          end else if (tick_q && brk_hit) begin
            state_q <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (run_p) begin
            state_q <= ST_RUN;
          end else if (step_p) begin
            state_q <= ST_STEP;
          end
        end
        ST_STEP: begin
          if (exec_ok) begin
            state_q <= ST_HALT;
          end
        end
        default: begin
          state_q <= ST_HALT;
        end
      endcase
    end
  end

  // leaving a halt must not re-trigger on the address we stopped at
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else if (!done_q || reset_p) begin
      skip_q <= 1'b0;
    end else if ((state_q == ST_HALT) && (run_p || step_p)) begin
      skip_q <= 1'b1;
    end else if (exec_ok) begin
      skip_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_exec_en <= 1'b0;
      cpu_reset <= 1'b1;
      reset_vector <= {RESET_BANK, RESET_PAGE, RESET_STEP};
    end else begin
      cpu_exec_en <= exec_ok;
      cpu_reset <= !done_q || reset_p;
      reset_vector <= {RESET_BANK, RESET_PAGE, RESET_STEP};
    end
  end

  // ***************************************************************
  // indicators, registered one cycle behind their sources
  // ***************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ram_addr <= '0;
      ram_leds <= '0;
      instruction_word_leds <= '0;
      pc_bank_leds <= '0;
      pc_page_leds <= '0;
      pc_step_leds <= '0;
      stack_ptr_leds <= '0;
      index_x_leds <= '0;
      index_y_leds <= '0;
      acc_a_leds <= '0;
      acc_b_leds <= '0;
      interrupt_flag_led <= 1'b0;
      decimal_flag_led <= 1'b0;
      zero_flag_led <= 1'b0;
      carry_flag_led <= 1'b0;
      heavy_load_led <= 1'b0;
      supply_detect_led <= 1'b0;
      fast_osc_led <= 1'b0;
      config_done_led <= 1'b0;
    end else begin
      ram_addr <= ram_select_switches;
      ram_leds <= ram_read_data;
      instruction_word_leds <= {prog_high_data, prog_low_data};
      pc_bank_leds <= pc_bank;
      pc_page_leds <= pc_page;
      pc_step_leds <= pc_step;
      stack_ptr_leds <= stack_ptr;
      index_x_leds <= index_x;
      index_y_leds <= index_y;
      acc_a_leds <= acc_a;
      acc_b_leds <= acc_b;
      interrupt_flag_led <= int_flag;
      decimal_flag_led <= dec_flag;
      zero_flag_led <= zero_flag;
      carry_flag_led <= carry_flag;
      heavy_load_led <= power_ctrl_reg[HEAVY_LOAD_POS];
      supply_detect_led <= power_ctrl_reg[SUPPLY_DETECT_POS];
      fast_osc_led <= osc_ctrl_reg[FAST_OSC_CTRL_POS];
      config_done_led <= done_q;
    end
  end

  // ***************************************************************
  // port3 bit3 pin
  // ***************************************************************
  // no real supply is taken in; the pin floats while the extra supply bit is set or port3_bit3_drive is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port3_bit3_pin_o <= 1'b0;
      port3_bit3_pin_oe_n <= 1'b1;
      port3_bit3_to_core <= 1'b0;
      extra_supply_led <= 1'b0;
    end else begin
      port3_bit3_pin_o <= port3_bit3_out;
      port3_bit3_pin_oe_n <= ctrl_q[CTRL_EXTRA_SUPPLY_POS] || !port3_bit3_drive;
      port3_bit3_to_core <= port3_bit3_pin_i;
      extra_supply_led <= ctrl_q[CTRL_EXTRA_SUPPLY_POS];
    end
  end

endmodule
`default_nettype wire

/* File: tb/core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic sys_clk,
  input wire logic cpu_exec_en,
  input wire logic cpu_reset,
  input wire logic [panel_pkg::PC_W-1:0] reset_vector,
  input wire logic [7:0] ram_addr,
  output logic [panel_pkg::BANK_W-1:0] pc_bank,
  output logic [panel_pkg::PAGE_W-1:0] pc_page,
  output logic [panel_pkg::STEP_W-1:0] pc_step,
  output logic [7:0] prog_low_data,
  output logic [3:0] prog_high_data,
  output logic [3:0] ram_read_data
);
  import panel_pkg::*;
  // ***************************************************************
  // core stand-in: pc loads the reset vector on cpu_reset, else moves only on an execute pulse
  // ***************************************************************
  logic [PC_W-1:0] pc_q;
  always_ff @(posedge sys_clk) begin
    if (cpu_reset) begin
      pc_q <= reset_vector;
    end else if (cpu_exec_en) begin
      pc_q <= pc_q + 13'h0001;
    end
  end
  assign {pc_bank, pc_page, pc_step} = pc_q;
  // code pattern differs from the address so a wrong pc shows up
  assign {prog_high_data, prog_low_data} = pc_q[11:0] ^ 12'h5A5;
  assign ram_read_data = ram_addr[3:0] ^ ram_addr[7:4] ^ 4'h9;
endmodule
`default_nettype wire

/* File: tb/debug_panel_props.sv */
`timescale 1ns/1ns
`default_nettype none
module debug_panel_props #(
  parameter int RAM_AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [RAM_AW-1:0] ram_select_switches,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [3:0] ram_read_data,
  input wire logic [3:0] ram_leds,
  input wire logic [7:0] prog_low_data,
  input wire logic [3:0] prog_high_data,
  input wire logic [11:0] instruction_word_leds,
  input wire logic [panel_pkg::STEP_W-1:0] pc_step,
  input wire logic [panel_pkg::STEP_W-1:0] pc_step_leds,
  input wire logic [7:0] stack_ptr,
  input wire logic [7:0] stack_ptr_leds,
  input wire logic carry_flag,
  input wire logic carry_flag_led,
  input wire logic [3:0] power_ctrl_reg,
  input wire logic heavy_load_led,
  input wire logic supply_detect_led,
  input wire logic cpu_exec_en,
  input wire logic cpu_reset,
  input wire logic [panel_pkg::PC_W-1:0] reset_vector,
  input wire logic config_done_led,
  input wire logic extra_supply_led,
  input wire logic port3_bit3_pin_oe_n
);
  import panel_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ***************************************************************
  // the past of a signal is only trusted one edge after reset
  // ***************************************************************
  sequence exec_pulse_s;
    cpu_exec_en ##1 !cpu_exec_en;
  endsequence
  sequence reset_pulse_s;
    cpu_reset ##1 !cpu_reset;
  endsequence
  bus_okay_a: assert property (!$past(rst) |-> hreadyout && !hresp)
    else $error("bus stalled or answered with an error");
  instr_leds_a: assert property (!$past(rst) |->
    instruction_word_leds == $past({prog_high_data, prog_low_data}))
    else $error("instruction leds do not show the program word");
  ram_path_a: assert property (!$past(rst) |->
    ram_addr == $past(ram_select_switches) && ram_leds == $past(ram_read_data))
    else $error("ram leds do not follow the selected location");
  pc_leds_a: assert property (!$past(rst) |-> pc_step_leds == $past(pc_step))
    else $error("step leds do not follow the pc");
  state_leds_a: assert property (!$past(rst) |->
    {stack_ptr_leds, carry_flag_led} == $past({stack_ptr, carry_flag}))
    else $error("state leds do not follow the core");
  power_leds_a: assert property (!$past(rst) |-> {heavy_load_led, supply_detect_led} ==
    $past({power_ctrl_reg[HEAVY_LOAD_POS], power_ctrl_reg[SUPPLY_DETECT_POS]}))
    else $error("power control leds wrong");
  reset_vec_a: assert property (reset_vector == {RESET_BANK, RESET_PAGE, RESET_STEP})
    else $error("reset vector wrong");
  exec_once_a: assert property ($rose(cpu_exec_en) |-> exec_pulse_s)
    else $error("execute pulse longer than one cycle");
  exec_gate_a: assert property (cpu_exec_en |-> config_done_led)
    else $error("execution before configuration done");
  done_hold_a: assert property (config_done_led |=> config_done_led)
    else $error("configuration done dropped");
  key_reset_a: assert property (config_done_led && $past(config_done_led) && $rose(cpu_reset) |-> reset_pulse_s)
    else $error("reset key pulse not one cycle");
  extra_float_a: assert property (extra_supply_led && $past(extra_supply_led) |-> port3_bit3_pin_oe_n)
    else $error("extra supply pin still driven");
endmodule
bind debug_panel debug_panel_props #(.RAM_AW(RAM_AW)) props (.sys_clk, .rst, .hreadyout, .hresp,
  .ram_select_switches, .ram_addr, .ram_read_data, .ram_leds, .prog_low_data, .prog_high_data,
  .instruction_word_leds, .pc_step, .pc_step_leds, .stack_ptr, .stack_ptr_leds, .carry_flag, .carry_flag_led,
  .power_ctrl_reg, .heavy_load_led, .supply_detect_led, .cpu_exec_en, .cpu_reset, .reset_vector,
  .config_done_led, .extra_supply_led, .port3_bit3_pin_oe_n);
`default_nettype wire

/* File: tb/tb_debug_panel.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_debug_panel;
  import panel_pkg::*;
  // short debounce keeps key presses to a few dozen cycles
  localparam int DB = 4;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, break_enable_switch, pin_ext;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize, key_v;
  logic [BANK_W-1:0] break_bank_switches, pc_bank, pc_bank_leds;
  logic [3:0] break_page_switches, pc_page, pc_page_leds, prog_high_data, ram_read_data, ram_leds;
  logic [3:0] acc_a, acc_b, acc_a_leds, acc_b_leds, power_ctrl_reg, osc_ctrl_reg;
  logic [7:0] break_step_switches, pc_step, pc_step_leds, ram_select_switches, ram_addr;
  logic [7:0] prog_low_data, stack_ptr, stack_ptr_leds;
  logic [11:0] index_x, index_y, index_x_leds, index_y_leds, instruction_word_leds;
  logic [PC_W-1:0] reset_vector, p, q;
  logic int_flag, dec_flag, zero_flag, carry_flag, interrupt_flag_led, decimal_flag_led, zero_flag_led;
  logic carry_flag_led, heavy_load_led, supply_detect_led, fast_osc_led, extra_supply_led, config_done_led;
  logic port3_bit3_out, port3_bit3_drive, port3_bit3_pin_o, port3_bit3_pin_oe_n, port3_bit3_to_core;
  logic cpu_exec_en, cpu_reset;
  int failures, comparisons, n;
  wire logic hready = hreadyout;
  wire logic run_key = key_v[KEY_RUN];
  wire logic step_key = key_v[KEY_STEP];
  wire logic reset_switch = key_v[KEY_RESET];
  wire logic port3_bit3_pin_i = port3_bit3_pin_oe_n ? pin_ext : port3_bit3_pin_o;

  debug_panel #(.DEBOUNCE(DB), .RAM_AW(8)) DUT (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .break_enable_switch, .break_bank_switches,
    .break_page_switches, .break_step_switches, .ram_select_switches, .run_key, .step_key, .reset_switch,
    .pc_bank, .pc_page, .pc_step, .prog_low_data, .prog_high_data, .ram_read_data, .stack_ptr, .index_x,
    .index_y, .acc_a, .acc_b, .int_flag, .dec_flag, .zero_flag, .carry_flag, .power_ctrl_reg, .osc_ctrl_reg,
    .port3_bit3_out, .port3_bit3_drive, .port3_bit3_pin_i, .port3_bit3_pin_o, .port3_bit3_pin_oe_n,
    .port3_bit3_to_core, .cpu_exec_en, .cpu_reset, .reset_vector, .ram_addr, .ram_leds,
    .instruction_word_leds, .pc_bank_leds, .pc_page_leds, .pc_step_leds, .stack_ptr_leds, .index_x_leds,
    .index_y_leds, .acc_a_leds, .acc_b_leds, .interrupt_flag_led, .decimal_flag_led, .zero_flag_led,
    .carry_flag_led, .heavy_load_led, .supply_detect_led, .fast_osc_led, .extra_supply_led, .config_done_led);
  core_model PM (.sys_clk, .cpu_exec_en, .cpu_reset, .reset_vector, .ram_addr, .pc_bank, .pc_page,
    .pc_step, .prog_low_data, .prog_high_data, .ram_read_data);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tmo;
    failures++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) tmo();
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic wstat(input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0, r);
      k++;
    end while (r[b] !== v && k < 2000);
    if (r[b] !== v) tmo();
  endtask
  task automatic press(input int k);
    key_v[k] <= 1'b1;
    cyc(3 * DB);
    key_v[k] <= 1'b0;
    cyc(3 * DB);
  endtask
  task automatic period(output int c);
    int k;
    k = 0;
    c = 0;
    while (cpu_exec_en !== 1'b1 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    do begin
      @(negedge sys_clk);
      c++;
    end while (cpu_exec_en !== 1'b1 && c < 2000);
    if (k >= 2000 || c >= 2000) tmo();
    @(posedge sys_clk);
  endtask
  task automatic randst;
    logic [31:0] v;
    v = $urandom;
    {stack_ptr, index_x, index_y} <= $urandom;
    {acc_a, acc_b, power_ctrl_reg, osc_ctrl_reg} <= v[15:0];
    {int_flag, dec_flag, zero_flag, carry_flag} <= v[19:16];
    ram_select_switches <= v[27:20];
    {port3_bit3_out, pin_ext} <= v[29:28];
  endtask
  task automatic brk(input logic [PC_W-1:0] a, input logic en);
    {break_bank_switches, break_page_switches, break_step_switches} <= a;
    break_enable_switch <= en;
  endtask
  function automatic logic [PC_W-1:0] pcv;
    return {pc_bank, pc_page, pc_step};
  endfunction
  function automatic logic [11:0] exp_word(input logic [PC_W-1:0] a);
    return a[11:0] ^ 12'h5A5;
  endfunction
  function automatic logic [3:0] exp_ram(input logic [7:0] s);
    return s[3:0] ^ s[7:4] ^ 4'h9;
  endfunction
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    r = $urandom(32'hBE7C);
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    {hsel, hwrite, break_enable_switch, port3_bit3_drive, key_v, htrans, hsize} = '0;
    {haddr, hwdata} = '0;
    {break_bank_switches, break_page_switches, break_step_switches} = '0;
    randst();
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    wstat(STAT_DONE_POS, 1'b1);
    chk(32'(pcv()), 32'({RESET_BANK, RESET_PAGE, RESET_STEP}));
    bus(1'b0, ADDR_CTRL, 32'h0, r);
    chk(r, 32'(CTRL_RESET));
    period(n);
    chk(n, SLOW_DIV);
    bus(1'b1, ADDR_CTRL, 32'h1, r);
    repeat (2) period(n);
    chk(n, FAST_DIV);
    p = pcv() + PC_W'(6 + $urandom_range(4));
    brk(p, 1'b1);
    wstat(STAT_HALT_POS, 1'b1);
    cyc(100);
    chk(32'(pcv()), 32'(p));
    bus(1'b0, ADDR_PC, 32'h0, r);
    chk(r, 32'(p));
    for (int i = 0; i < 12; i++) begin
      randst();
      cyc(3);
      @(negedge sys_clk);
      chk({stack_ptr_leds, index_x_leds, index_y_leds}, {stack_ptr, index_x, index_y});
      chk(32'({acc_a_leds, acc_b_leds, interrupt_flag_led, decimal_flag_led, zero_flag_led, carry_flag_led}),
        32'({acc_a, acc_b, int_flag, dec_flag, zero_flag, carry_flag}));
      chk(32'({heavy_load_led, supply_detect_led, fast_osc_led}), 32'({power_ctrl_reg[HEAVY_LOAD_POS],
        power_ctrl_reg[SUPPLY_DETECT_POS], osc_ctrl_reg[FAST_OSC_CTRL_POS]}));
      chk(32'({ram_leds, instruction_word_leds}), 32'({exp_ram(ram_select_switches), exp_word(p)}));
      chk(32'({pc_bank_leds, pc_page_leds, pc_step_leds}), 32'(p));
      @(posedge sys_clk);
    end
    press(KEY_RUN);
    cyc(60);
    chk(32'(pcv() > p), 32'h1);
    press(KEY_STEP);
    q = pcv();
    cyc(100);
    chk(32'(pcv()), 32'(q));
    for (int i = 1; i < 3; i++) begin
      press(KEY_STEP);
      cyc(60);
      chk(32'(pcv()), 32'(q + PC_W'(i)));
    end
    brk(q + 13'h0008, 1'b0);
    press(KEY_RUN);
    cyc(400);
    chk(32'(pcv() > q + 13'h0008), 32'h1);
    brk({RESET_BANK, RESET_PAGE, RESET_STEP}, 1'b1);
    press(KEY_RESET);
    wstat(STAT_HALT_POS, 1'b1);
    chk(32'(pcv()), 32'({RESET_BANK, RESET_PAGE, RESET_STEP}));
    bus(1'b0, ADDR_STATUS, 32'h0, r);
    chk(r, 32'((1 << STAT_HALT_POS) | (1 << STAT_DONE_POS) | (1 << STAT_CLK_SEL_POS)));
    for (int i = 0; i < 4; i++) begin
      port3_bit3_drive <= i[0];
      bus(1'b1, ADDR_CTRL, {30'h0, i[1], 1'b1}, r);
      cyc(3);
      chk(32'({extra_supply_led, port3_bit3_pin_oe_n, port3_bit3_to_core}), 32'({i[1], i[1] | !i[0],
        (i[1] | !i[0]) ? pin_ext : port3_bit3_out}));
    end
    bus(1'b1, 32'h0000_0010, $urandom, r);
    bus(1'b0, 32'h0000_0010, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0, r);
    chk(r, 32'h3);
    finish_test();
  end
endmodule
`default_nettype wire
